// *** hdl/pixel_stage_pkg.sv ***
// constants shared by the pixel input stage and its buffer
package pixel_stage_pkg;
  // ****************************************************************
  // widths and word layout
  // ****************************************************************
  localparam int COLOR_W     = 8;
  localparam int WORD_W      = 26;
  localparam int RED_LSB     = 18;
  localparam int GREEN_LSB   = 10;
  localparam int BLUE_LSB    = 2;
  localparam int SUPPRESS_BIT = 1;
  localparam int TIMING_BIT  = 0;
  localparam int BUF_DEPTH   = 2;
  localparam int GRAY_LEVELS = 256;
  // ****************************************************************
  // codes and reset values
  // ****************************************************************
  localparam logic [7:0]  BLACK_CODE = 8'h00;
  localparam logic [7:0]  WHITE_CODE = 8'hFF;
  localparam logic [25:0] WORD_RESET = 26'h000_0000;
  localparam logic [1:0]  PTR_RESET  = 2'h0;
endpackage

// *** hdl/pixel_word_if.sv ***
// carrier between the pixel stage and its two-entry buffer
`timescale 1ns/1ps
interface pixel_word_if;
  logic        wrValid;
  logic        wrReady;
  logic [25:0] wrWord;
  logic        rdValid;
  logic        rdReady;
  logic [25:0] rdWord;
  modport store
  (
    input  wrValid,
    input  wrWord,
    input  rdReady,
    output wrReady,
    output rdValid,
    output rdWord
  );
  modport user
  (
    output wrValid,
    output wrWord,
    output rdReady,
    input  wrReady,
    input  rdValid,
    input  rdWord
  );
endinterface

// *** hdl/pixel_word_buffer.sv ***
// two-entry buffer holding captured pixel words
`timescale 1ns/1ps
module pixel_word_buffer
(
  // clock and reset
  input wire logic     sys_clk,
  input wire logic     reset,
  // words in and out
  pixel_word_if.store  bus
);
  logic [25:0] mem [pixel_stage_pkg::BUF_DEPTH];
  logic        wrPtr;
  logic        rdPtr;
  logic [1:0]  count;
  logic        notFull;
  logic        doWrite;
  logic        doRead;

  assign doWrite     = bus.wrValid && notFull;
  assign doRead      = bus.rdReady && (count != pixel_stage_pkg::PTR_RESET);
  assign bus.wrReady = notFull;
  assign bus.rdValid = (count != pixel_stage_pkg::PTR_RESET);
  assign bus.rdWord  = mem[rdPtr];

  // the write into an entry is the rising-edge capture of the pins
  always_ff @(posedge sys_clk)
  begin
    if (doWrite)
    begin
      mem[wrPtr] <= bus.wrWord;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wrPtr   <= 1'b0;
      rdPtr   <= 1'b0;
      count   <= pixel_stage_pkg::PTR_RESET;
      notFull <= 1'b1;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr <= ~wrPtr;
      end
      if (doRead)
      begin
        rdPtr <= ~rdPtr;
      end
      case ({doWrite, doRead})
        2'b10:
        begin
          count   <= count + 2'h1;
          notFull <= (count == 2'h0);
        end
        2'b01:
        begin
          count   <= count - 2'h1;
          notFull <= 1'b1;
        end
        default:
        begin
          count   <= count;
          notFull <= notFull;
        end
      endcase
    end
  end
endmodule

// *** hdl/rgb_pixel_input_stage.sv ***
// pixel and control capture stage feeding three 8-bit converters
`timescale 1ns/1ps
module rgb_pixel_input_stage
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // pixel and control pins from the timing controller
  input  wire logic [7:0] red_pixel_bits,
  input  wire logic [7:0] green_pixel_bits,
  input  wire logic [7:0] blue_pixel_bits,
  input  wire logic       pictureSuppressN,
  input  wire logic       compositeTimingN,
  input  wire logic       pixelValid,
  output logic            pixelReady,
  // power control
  input  wire logic       low_power_request,
  output logic            powerDown,
  // converter side
  output logic [7:0]      redCode,
  output logic [7:0]      greenCode,
  output logic [7:0]      blueCode,
  output logic            greenOffsetOn,
  output logic            blankActive,
  output logic            outValid,
  input  wire logic       outReady
);
  // ****************************************************************
  // buffer in the data path
  // ****************************************************************
  pixel_word_if bus ();
  logic        fire;
  logic        readyReg;
  logic [7:0]  rdRed;
  logic [7:0]  rdGreen;
  logic [7:0]  rdBlue;
  logic        rdSuppressN;
  logic        rdTimingN;

  assign bus.wrValid = pixelValid;
  // controls ride in the same word as the pixels
  assign bus.wrWord  = {red_pixel_bits, green_pixel_bits, blue_pixel_bits,
                        pictureSuppressN, compositeTimingN};
  assign bus.rdReady = !outValid || outReady;
  assign fire        = bus.rdValid && bus.rdReady;
  assign pixelReady  = readyReg;

  // bit 0 of each slice is the code's least significant bit
  assign rdRed = bus.rdWord[pixel_stage_pkg::RED_LSB +: 8];
  assign rdGreen = bus.rdWord[pixel_stage_pkg::GREEN_LSB +: 8];
  assign rdBlue = bus.rdWord[pixel_stage_pkg::BLUE_LSB +: 8];
  assign rdSuppressN = bus.rdWord[pixel_stage_pkg::SUPPRESS_BIT];
  assign rdTimingN   = bus.rdWord[pixel_stage_pkg::TIMING_BIT];

  pixel_word_buffer u_buffer
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .bus     (bus.store)
  );

  // ****************************************************************
  // ready flag, kept in step with the buffer's not-full state so that
  // the source never offers a word the buffer must drop
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      readyReg <= 1'b1;
    end
    else
    begin
      case ({bus.wrValid && readyReg, fire})
        2'b10:
        begin
          readyReg <= !bus.rdValid;
        end
        2'b01:
        begin
          readyReg <= 1'b1;
        end
        default:
        begin
          readyReg <= readyReg;
        end
      endcase
    end
  end

  // ****************************************************************
  // output stage: codes and current enables
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      outValid <= 1'b0;
    end
    else if (bus.rdReady)
    begin
      outValid <= bus.rdValid;
    end
  end

  // three separate channel registers, each 256 levels wide
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      redCode   <= pixel_stage_pkg::BLACK_CODE;
      greenCode <= pixel_stage_pkg::BLACK_CODE;
      blueCode  <= pixel_stage_pkg::BLACK_CODE;
    end
    else if (fire)
    begin
      if (rdSuppressN)
      begin
        redCode   <= rdRed;
        greenCode <= rdGreen;
        blueCode  <= rdBlue;
      end
      else
      begin
        redCode   <= pixel_stage_pkg::BLACK_CODE;
        greenCode <= pixel_stage_pkg::BLACK_CODE;
        blueCode  <= pixel_stage_pkg::BLACK_CODE;
      end
    end
  end

  // weighted current enables from the held controls
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      greenOffsetOn <= 1'b0;
      blankActive   <= 1'b1;
    end
    else if (fire)
    begin
      greenOffsetOn <= rdTimingN;
      blankActive   <= !rdSuppressN;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      powerDown <= 1'b0;
    end
    else
    begin
      powerDown <= low_power_request;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_emptyTake;
    pixelValid && pixelReady && !bus.rdValid && !outValid;
  endsequence

  sequence s_showUp;
    bus.rdValid ##1 outValid;
  endsequence

  property p_captureReach;
    @(posedge sys_clk) disable iff (reset)
    s_emptyTake |=> s_showUp;
  endproperty
  a_captureReach: assert property (p_captureReach)
    else $error("captured pixel did not reach the output stage");

  property p_suppressIgnores;
    @(posedge sys_clk) disable iff (reset)
    fire && !rdSuppressN |=> redCode == 8'h00 && greenCode == 8'h00
      && blueCode == 8'h00 && blankActive;
  endproperty
  a_suppressIgnores: assert property (p_suppressIgnores)
    else $error("suppressed pixel did not give blank codes");

  property p_channelsIndependent;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    @(posedge sys_clk) disable iff (reset)
    (fire && rdSuppressN, r = rdRed, g = rdGreen, b = rdBlue)
      |=> redCode == r && greenCode == g && blueCode == b && !blankActive;
  endproperty
  a_channelsIndependent: assert property (p_channelsIndependent)
    else $error("channel code does not match its own input");

  property p_whiteCode;
    @(posedge sys_clk) disable iff (reset)
    fire && rdSuppressN && rdGreen == 8'hFF |=> greenCode == 8'hFF;
  endproperty
  a_whiteCode: assert property (p_whiteCode)
    else $error("full-scale input did not give white code");

  property p_offsetFollows;
    @(posedge sys_clk) disable iff (reset)
    fire |=> greenOffsetOn == $past(rdTimingN);
  endproperty
  a_offsetFollows: assert property (p_offsetFollows)
    else $error("green offset enable does not follow timing control");

  property p_holdStable;
    @(posedge sys_clk) disable iff (reset)
    outValid && !outReady |=> $stable(redCode) && $stable(greenCode)
      && $stable(blueCode) && $stable(greenOffsetOn) && outValid;
  endproperty
  a_holdStable: assert property (p_holdStable)
    else $error("output changed while stalled");

  property p_powerFollows;
    @(posedge sys_clk) disable iff (reset)
    low_power_request [*2] |-> powerDown;
  endproperty
  a_powerFollows: assert property (p_powerFollows)
    else $error("power down not entered on request");

  property p_stallReaches;
    @(posedge sys_clk) disable iff (reset)
    outValid && !outReady && pixelValid && pixelReady ##1
      pixelValid && pixelReady && !outReady |=> !pixelReady;
  endproperty
  a_stallReaches: assert property (p_stallReaches)
    else $error("buffer full but ready still high");
endmodule

// *** testbench/pixel_source_model.sv ***
// behavioural timing controller presenting pixels and controls
`timescale 1ns/1ps
module pixel_source_model
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // scenario control
  input  wire logic       run,
  input  wire logic       blankMode,
  input  wire logic       syncMode,
  input  wire logic       syncUnused,
  // pins toward the stage
  input  wire logic       pixelReady,
  output logic [7:0]      redBits,
  output logic [7:0]      greenBits,
  output logic [7:0]      blueBits,
  output logic            suppressN,
  output logic            timingN,
  output logic            pixelValid
);
  logic [7:0] idx;
  initial
  begin
    idx = 8'h00;
    pixelValid = 1'b0;
    redBits = 8'h00;
    greenBits = 8'h00;
    blueBits = 8'h00;
    suppressN = 1'b1;
    timingN = 1'b1;
  end
  always @(negedge sys_clk)
  begin
    if (reset)
      idx = 8'h00;
    else if (pixelValid)
      idx = idx + 8'h01;
    // one word a dot clock, paused while the buffer is full
    pixelValid = run && pixelReady && !reset;
    // idle data lines wander instead of holding the last word
    redBits = pixelValid ? idx : ~redBits;
    greenBits = pixelValid ? ~idx : ~greenBits;
    blueBits = pixelValid ? (idx ^ 8'h5A) : ~blueBits;
    suppressN = !blankMode;
    // timing pulled low only inside blanking, or held low when unused
    timingN = !(blankMode && syncMode) && !syncUnused;
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the pixel input stage
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk;
  logic        reset;
  logic        run;
  logic        blankMode;
  logic        syncMode;
  logic        low_power_request;
  logic        outReady;
  logic [7:0]  redBits;
  logic [7:0]  greenBits;
  logic [7:0]  blueBits;
  logic        suppressN;
  logic        timingN;
  logic        pixelValid;
  logic        pixelReady;
  logic        powerDown;
  logic [7:0]  redCode;
  logic [7:0]  greenCode;
  logic [7:0]  blueCode;
  logic        greenOffsetOn;
  logic        blankActive;
  logic        outValid;
  logic        watch;
  logic        syncUnused;
  logic        havePrev;
  logic        wasStall;
  logic [7:0]  lastRed;
  logic [23:0] held;
  int          nMismatch;
  int          compares;
  int          nTaken;

  rgb_pixel_input_stage i_rgb_pixel_input_stage
  (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .red_pixel_bits    (redBits),
    .green_pixel_bits  (greenBits),
    .blue_pixel_bits   (blueBits),
    .pictureSuppressN  (suppressN),
    .compositeTimingN  (timingN),
    .pixelValid        (pixelValid),
    .pixelReady        (pixelReady),
    .low_power_request (low_power_request),
    .powerDown         (powerDown),
    .redCode           (redCode),
    .greenCode         (greenCode),
    .blueCode          (blueCode),
    .greenOffsetOn     (greenOffsetOn),
    .blankActive       (blankActive),
    .outValid          (outValid),
    .outReady          (outReady)
  );
  pixel_source_model i_pixel_source_model
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .run        (run),
    .blankMode  (blankMode),
    .syncMode   (syncMode),
    .syncUnused (syncUnused),
    .pixelReady (pixelReady),
    .redBits    (redBits),
    .greenBits  (greenBits),
    .blueBits   (blueBits),
    .suppressN  (suppressN),
    .timingN    (timingN),
    .pixelValid (pixelValid)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (nMismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // stop the source, then wait a bounded time for the pipe to empty
  task automatic drain;
    int i;
    run <= 1'b0;
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < 40 && outValid !== 1'b0; i++)
      @(negedge sys_clk);
    if (outValid !== 1'b0)
    begin
      nMismatch++;
      tally_and_finish;
    end
  endtask

  // ****************************************************************
  // output monitor
  // ****************************************************************
  always @(negedge sys_clk)
  begin
    if (wasStall)
      chk({redCode, greenCode, blueCode}, held);
    if (watch && outValid === 1'b1 && outReady === 1'b1)
    begin
      nTaken++;
      if (blankMode)
      begin
        chk({redCode, greenCode, blueCode}, 24'h00_0000);
        chk({blankActive, greenOffsetOn}, {1'b1, !syncMode});
        havePrev = 1'b0;
      end
      else
      begin
        chk({greenCode, blueCode}, {~redCode, redCode ^ 8'h5A});
        if (havePrev)
          chk(redCode, lastRed + 8'h01);
        chk({blankActive, greenOffsetOn}, {1'b0, !syncUnused});
        lastRed = redCode;
        havePrev = 1'b1;
      end
    end
    held = {redCode, greenCode, blueCode};
  end
  // stall as the design saw it at the rising edge
  always @(posedge sys_clk)
  begin
    wasStall <= watch && outValid === 1'b1 && outReady !== 1'b1;
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_stream;
    nTaken = 0;
    run <= 1'b1;
    repeat (40) @(negedge sys_clk);
    drain;
    chk(24'(nTaken), 24'h00_0028);
  endtask
  task automatic t_stall;
    nTaken = 0;
    run <= 1'b1;
    repeat (5) @(negedge sys_clk);
    outReady <= 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(pixelReady, 1'b0);
    outReady <= 1'b1;
    repeat (10) @(negedge sys_clk);
    drain;
    chk(24'(nTaken), 24'h00_000F);
  endtask
  task automatic t_blank(input logic s);
    blankMode <= 1'b1;
    syncMode <= s;
    @(negedge sys_clk);
    run <= 1'b1;
    repeat (6) @(negedge sys_clk);
    drain;
    blankMode <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_power;
    low_power_request <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(powerDown, 1'b1);
    low_power_request <= 1'b0;
    @(negedge sys_clk);
    chk(powerDown, 1'b0);
  endtask
  // timing control held low throughout: green loses its offset
  task automatic t_no_sync;
    syncUnused <= 1'b1;
    t_stream;
    syncUnused <= 1'b0;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {run, blankMode, syncMode, syncUnused, low_power_request} = 5'h00;
    {watch, havePrev} = 2'h0;
    outReady = 1'b1;
    nMismatch = 0;
    compares = 0;
    repeat (10) @(negedge sys_clk);
    chk({pixelReady, powerDown, greenOffsetOn, blankActive, outValid},
        5'b10010);
    chk({redCode, greenCode, blueCode}, 24'h00_0000);
    reset <= 1'b0;
    watch = 1'b1;
    t_stream;
    t_stall;
    t_blank(1'b0);
    t_blank(1'b1);
    t_stream;
    t_no_sync;
    t_power;
    tally_and_finish;
  end
endmodule
